// [rtl/mac_transmit_control.sv]
// Purpose: transmit front end: bid, buffer fill, framing, pad, crc, events
// Assumes: pins LINK, CARRIER, COLL, HEARTBEAT, OVERLONG are asynchronous
// Notes: backoff timing lives outside; collisions retry from the buffer
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.svh"

module mac_transmit_control
    import tx_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic [11:0] HOST_ADDR_I,
    input wire logic [15:0] HOST_WDATA_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    output logic [15:0] HOST_RDATA_O,
    input wire logic LINK_I,
    input wire logic CARRIER_I,
    input wire logic COLL_I,
    input wire logic HEARTBEAT_ERR_I,
    input wire logic OVERLONG_I,
    input wire logic TX_READY_I,
    output logic [7:0] TX_DATA_O,
    output logic TX_VALID_O,
    output logic PORT_AUI_O,
    output logic MOD_BACKOFF_O,
    output logic DEFER_2PART_DIS_O,
    output logic TX_IRQ_O
);
    ctl_s s;
    ctl_s n;
    tx_buf_if buf_bus ();
    logic [9:0] ev;
    logic [9:0] en;
    logic link;
    logic aui;
    logic allowed;
    logic [10:0] thr;
    logic active;
    logic fire;
    logic starved;
    logic pad_need;
    logic crc_on;
    logic [7:0] cur;
    logic [31:0] fcs_sh;

    tx_buf_mem u_mem (
        .clk_i(SYS_CLK_I),
        .bus(buf_bus.mem)
    );

    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? `CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    assign link = s.s2[`PIN_LINK];
    // port choice, manual overrides automatic
    assign aui = s.line_ctl[`LC_AUI_ONLY] |
        (s.line_ctl[`LC_AUTO_SEL] & ~link);
    assign allowed = s.line_ctl[`LC_TX_EN] & (aui | link |
        s.test_ctl[`TC_LINK_TEST_DIS]);
    always_comb begin
        case (s.tx_cmd[`CMD_START_LO +: 2])
            2'b00: thr = `THR_SMALL;
            2'b01: thr = `THR_MID;
            2'b10: thr = `THR_LARGE;
            default: thr = s.len;
        endcase
    end
    assign active = s.st == ST_PRE || s.st == ST_DATA || s.st == ST_PAD ||
        s.st == ST_FCS;
    assign starved = s.st == ST_DATA && s.idx >= s.wbytes;
    assign fire = active && !starved && TX_READY_I;
    assign pad_need = !s.tx_cmd[`CMD_PAD_DIS] && s.len < `PAD_BYTES;
    assign crc_on = !s.tx_cmd[`CMD_INHIBIT_CRC];
    assign fcs_sh = ~s.crc >> {s.bcnt, 3'b000};
    always_comb begin
        case (s.st)
            ST_PRE: cur = (s.bcnt == `PRE_LAST) ? `SFD_BYTE : `PRE_BYTE;
            ST_DATA: cur = s.idx[0] ? buf_bus.rd[15:8] : buf_bus.rd[7:0];
            ST_FCS: cur = fcs_sh[7:0];
            default: cur = 8'h00;
        endcase
    end

    // enables read live every cycle
    assign en = {s.tx_cfg[`XC_EXCESS], s.tx_cfg[`XC_ANY_COL],
        s.tx_cfg[`XC_OVERLONG], s.tx_cfg[`XC_LATE_COL],
        s.tx_cfg[`XC_TX_DONE], s.tx_cfg[`XC_HEARTBEAT],
        s.tx_cfg[`XC_CARRIER_LOSS], s.buf_cfg[`BC_COL_OVF],
        s.buf_cfg[`BC_UNDERRUN], s.buf_cfg[`BC_SPACE_READY]};

    always_comb begin
        n = s;
        ev = 10'h000;
        n.s1 = {OVERLONG_I, HEARTBEAT_ERR_I, COLL_I, CARRIER_I, LINK_I};
        n.s2 = s.s1;
        n.s3 = s.s2;
        buf_bus.we = 1'b0;
        buf_bus.wa = s.wbytes[10:1];
        buf_bus.wd = HOST_WDATA_I;
        // frame engine
        case (s.st)
            ST_IDLE: begin
                if (s.pend) begin
                    n.pend = 1'b0;
                    n.ready = 1'b1;
                    n.wbytes = 11'd0;
                    n.tries = 4'd0;
                    n.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if ((s.wbytes >= thr || s.wbytes == s.len) && allowed) begin
                    n.st = ST_PRE;
                    n.bcnt = 3'd0;
                end
            end
            ST_PRE: begin
                if (fire) begin
                    n.bcnt = 3'(s.bcnt + 3'd1);
                    if (s.bcnt == `PRE_LAST) begin
                        n.st = ST_DATA;
                        n.idx = 11'd0;
                        n.crc = `CRC_INIT;
                        ev[3] = aui & ~s.s2[`PIN_CARRIER];
                    end
                end
            end
            ST_DATA: begin
                if (starved) begin
                    ev[1] = 1'b1;
                    n.ready = 1'b0;
                    n.st = ST_IDLE;
                end else if (fire) begin
                    n.crc = crc_byte(s.crc, cur);
                    n.idx = 11'(s.idx + 11'd1);
                    n.bcnt = 3'd0;
                    if (11'(s.idx + 11'd1) == s.len) begin
                        if (pad_need) begin
                            n.st = ST_PAD;
                        end else begin
                            n.st = crc_on ? ST_FCS : ST_DONE;
                        end
                    end
                end
            end
            ST_PAD: begin
                if (fire) begin
                    n.crc = crc_byte(s.crc, cur);
                    n.idx = 11'(s.idx + 11'd1);
                    if (11'(s.idx + 11'd1) == `PAD_BYTES) begin
                        n.st = crc_on ? ST_FCS : ST_DONE;
                    end
                end
            end
            ST_FCS: begin
                if (fire) begin
                    n.bcnt = 3'(s.bcnt + 3'd1);
                    if (s.bcnt == `FCS_LAST) begin
                        n.st = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                ev[5] = 1'b1;
                n.ready = 1'b0;
                n.st = ST_IDLE;
            end
            default: n.st = ST_IDLE;
        endcase
        // collision on the wire
        if (active && s.s2[`PIN_COLL] && !s.s3[`PIN_COLL]) begin
            ev[8] = 1'b1;
            n.col_cnt = 10'(s.col_cnt + 10'd1);
            ev[2] = &s.col_cnt;
            if (s.st != ST_PRE && s.idx >= `LATE_BYTES) begin
                ev[6] = 1'b1;
                n.ready = 1'b0;
                n.st = ST_IDLE;
            end else if (s.tx_cmd[`CMD_ONE_COLL] || s.tries == `MAX_TRIES) begin
                ev[9] = s.tries == `MAX_TRIES;
                n.ready = 1'b0;
                n.st = ST_IDLE;
            end else begin
                n.tries = 4'(s.tries + 4'd1);
                n.st = ST_LOAD;
            end
        end
        ev[4] = s.s2[`PIN_HEARTBEAT] & ~s.s3[`PIN_HEARTBEAT];
        ev[7] = s.s2[`PIN_OVERLONG] & ~s.s3[`PIN_OVERLONG];
        // host register port
        if (HOST_RD_I) begin
            case (HOST_ADDR_I)
                `A_LINE_CTL: n.rdata = s.line_ctl;
                `A_BUF_CFG: n.rdata = s.buf_cfg;
                `A_TX_CFG: n.rdata = s.tx_cfg;
                `A_TEST_CTL: n.rdata = s.test_ctl;
                `A_TX_CMD: n.rdata = s.tx_cmd;
                `A_TX_LEN: n.rdata = {5'h00, s.len};
                `A_BUS_ST: n.rdata = {7'h00, s.ready, s.bid_err, 7'h00};
                default: n.rdata = 16'h0000;
            endcase
        end
        if (HOST_WR_I) begin
            case (HOST_ADDR_I)
                `A_LINE_CTL: n.line_ctl = HOST_WDATA_I;
                `A_BUF_CFG: n.buf_cfg = HOST_WDATA_I;
                `A_TX_CFG: n.tx_cfg = HOST_WDATA_I;
                `A_TEST_CTL: n.test_ctl = HOST_WDATA_I;
                `A_TX_CMD: begin
                    n.tx_cmd = HOST_WDATA_I;
                    n.pend = 1'b0;
                    n.bid_err = 1'b0;
                    if (HOST_WDATA_I[`CMD_FORCE]) begin
                        n.ready = 1'b0;
                        n.st = ST_IDLE;
                    end
                end
                `A_TX_LEN: begin
                    if (HOST_WDATA_I > {5'h00, `LEN_MAX} ||
                        HOST_WDATA_I < {5'h00, `LEN_MIN}) begin
                        n.bid_err = 1'b1;
                        n.pend = 1'b0;
                    end else begin
                        n.len = HOST_WDATA_I[10:0];
                        n.pend = 1'b1;
                    end
                end
                `A_TX_DATA: begin
                    if (s.ready && s.wbytes < s.len) begin
                        buf_bus.we = 1'b1;
                        n.wbytes = (11'(s.wbytes + 11'd2) > s.len) ?
                            s.len : 11'(s.wbytes + 11'd2);
                    end
                end
                default: n.wbytes = n.wbytes;
            endcase
        end
        ev[0] = n.ready & ~s.ready;
        n.irq = |(ev & en);
        buf_bus.ra = n.idx[10:1];
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            s <= '{line_ctl: `RST_CFG, buf_cfg: `RST_CFG, tx_cfg: `RST_CFG,
                test_ctl: `RST_CFG, tx_cmd: 16'h0000, crc: `CRC_INIT,
                st: ST_IDLE, default: '0};
        end else begin
            s <= n;
        end
    end

    assign HOST_RDATA_O = s.rdata;
    assign TX_DATA_O = cur;
    assign TX_VALID_O = active && !starved && s.line_ctl[`LC_TX_EN];
    assign PORT_AUI_O = aui;
    assign MOD_BACKOFF_O = s.line_ctl[`LC_MOD_BACKOFF];
    assign DEFER_2PART_DIS_O = s.line_ctl[`LC_DEFER_DIS];
    assign TX_IRQ_O = s.irq;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RESET_I);

    a_start_at_thr: assert property (
        s.st == ST_LOAD && allowed && s.wbytes >= thr && !HOST_WR_I
        |=> s.st == ST_PRE && s.bcnt == 3'd0)
        else $error("preamble did not start at threshold");
    a_no_tx_disabled: assert property (
        s.st == ST_LOAD && !s.line_ctl[`LC_TX_EN] |=> s.st != ST_PRE)
        else $error("started with transmit disabled");
    a_port_forced: assert property (
        s.line_ctl[`LC_AUI_ONLY] |-> PORT_AUI_O)
        else $error("attachment port not forced");
    a_port_auto: assert property (
        !s.line_ctl[`LC_AUI_ONLY] && s.line_ctl[`LC_AUTO_SEL]
        |-> PORT_AUI_O == !link)
        else $error("automatic port choice wrong");
    a_link_block: assert property (
        s.st == ST_LOAD && !aui && !link && !s.test_ctl[`TC_LINK_TEST_DIS]
        |=> s.st != ST_PRE)
        else $error("sent on twisted pair without link");
    a_bid_error: assert property (
        HOST_WR_I && HOST_ADDR_I == `A_TX_LEN &&
        (HOST_WDATA_I < {5'h00, `LEN_MIN} || HOST_WDATA_I > {5'h00, `LEN_MAX})
        |=> s.bid_err && !s.pend)
        else $error("bad length not flagged");
    a_ready_grant: assert property (
        s.st == ST_IDLE && s.pend && !HOST_WR_I
        |=> s.ready ##1 (s.rdata[`BS_READY_NOW] || !$past(HOST_RD_I) ||
        $past(HOST_ADDR_I) != `A_BUS_ST))
        else $error("space ready not granted");
    a_pad_entry: assert property (
        s.st == ST_DATA && fire && 11'(s.idx + 11'd1) == s.len &&
        pad_need && !HOST_WR_I && !s.s2[`PIN_COLL]
        |=> s.st == ST_PAD [*1] ##0 s.idx == s.len)
        else $error("short frame not padded");
    a_crc_four: assert property (
        s.st == ST_FCS && fire && s.bcnt == `FCS_LAST && !HOST_WR_I &&
        !s.s2[`PIN_COLL] |=> s.st == ST_DONE)
        else $error("crc phase did not end after four bytes");
    a_underrun_ev: assert property (
        starved && s.buf_cfg[`BC_UNDERRUN] && !s.s2[`PIN_COLL]
        |=> TX_IRQ_O && s.st == ST_IDLE)
        else $error("underrun not reported");
    a_irq_gated: assert property (
        s.tx_cfg == 16'h0000 && s.buf_cfg == 16'h0000 |=> !TX_IRQ_O)
        else $error("interrupt without enabled event");

    c_frame_sent: cover property (s.st == ST_FCS ##[1:40] s.st == ST_DONE);
    c_padded: cover property (s.st == ST_PAD ##1 s.st == ST_PAD);
    c_underrun: cover property (starved);
    c_retry: cover property (active ##1 s.st == ST_LOAD);
endmodule
`default_nettype wire

// [rtl/tx_buf_if.sv]
// Purpose: port bundle between transmit control and its frame buffer
// Assumes: 1024 words of 16 bits
// Notes: read data is registered inside the buffer
`timescale 1ns/1ps
`default_nettype none
interface tx_buf_if;
    logic we;
    logic [9:0] wa;
    logic [15:0] wd;
    logic [9:0] ra;
    logic [15:0] rd;
    modport ctl (output we, output wa, output wd, output ra, input rd);
    modport mem (input we, input wa, input wd, input ra, output rd);
endinterface
`default_nettype wire

// [rtl/tx_buf_mem.sv]
// Purpose: transmit frame buffer, one write and one read port
// Assumes: a write and a read to one word in a cycle return the new word
// Notes: read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module tx_buf_mem (
    input wire logic clk_i,
    tx_buf_if.mem bus
);
    logic [15:0] mem [0:1023];
    logic [15:0] rd;

    always_ff @(posedge clk_i) begin
        if (bus.we) begin
            mem[bus.wa] <= bus.wd;
        end
        if (bus.we && bus.wa == bus.ra) begin
            rd <= bus.wd;
        end else begin
            rd <= mem[bus.ra];
        end
    end

    assign bus.rd = rd;
endmodule
`default_nettype wire

// [rtl/tx_map.svh]
// Purpose: offsets, field positions, reset values and counts for tx control
// Assumes: 16-bit host register port with 12-bit addresses
// Notes: included by the transmit control module, the host model and the bench
`ifndef TX_MAP_SVH
`define TX_MAP_SVH
`define A_TX_CFG 12'h106
`define A_BUF_CFG 12'h10a
`define A_LINE_CTL 12'h112
`define A_TEST_CTL 12'h118
`define A_BUS_ST 12'h138
`define A_TX_CMD 12'h144
`define A_TX_LEN 12'h146
`define A_TX_DATA 12'ha00
`define RST_CFG 16'h0000
`define LC_TX_EN 7
`define LC_AUI_ONLY 8
`define LC_AUTO_SEL 9
`define LC_MOD_BACKOFF 11
`define LC_DEFER_DIS 13
`define TC_LINK_TEST_DIS 7
`define BC_SPACE_READY 8
`define BC_UNDERRUN 9
`define BC_COL_OVF 12
`define XC_CARRIER_LOSS 6
`define XC_HEARTBEAT 7
`define XC_TX_DONE 8
`define XC_LATE_COL 9
`define XC_OVERLONG 10
`define XC_ANY_COL 11
`define XC_EXCESS 15
`define CMD_START_LO 6
`define CMD_FORCE 8
`define CMD_ONE_COLL 9
`define CMD_INHIBIT_CRC 12
`define CMD_PAD_DIS 13
`define BS_BID_ERR 7
`define BS_READY_NOW 8
`define THR_SMALL 11'd5
`define THR_MID 11'd381
`define THR_LARGE 11'd1021
`define LEN_MIN 11'd3
`define LEN_MAX 11'd1514
`define PAD_BYTES 11'd60
`define LATE_BYTES 11'd56
`define PRE_LAST 3'd7
`define FCS_LAST 3'd3
`define MAX_TRIES 4'd15
`define PRE_BYTE 8'h55
`define SFD_BYTE 8'hd5
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define PIN_LINK 0
`define PIN_CARRIER 1
`define PIN_COLL 2
`define PIN_HEARTBEAT 3
`define PIN_OVERLONG 4
`endif

// [rtl/tx_pkg.sv]
// Purpose: types shared by the transmit control design
// Assumes: nothing beyond the map header
// Notes: state codes are gray along idle-load-pre-data-pad-fcs-done
package tx_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOAD = 3'h1,
        ST_PRE = 3'h3,
        ST_DATA = 3'h2,
        ST_PAD = 3'h6,
        ST_FCS = 3'h7,
        ST_DONE = 3'h5
    } tx_state_e;

    typedef struct packed {
        logic [15:0] line_ctl;
        logic [15:0] buf_cfg;
        logic [15:0] tx_cfg;
        logic [15:0] test_ctl;
        logic [15:0] tx_cmd;
        logic [10:0] len;
        logic [10:0] wbytes;
        logic [10:0] idx;
        logic [2:0] bcnt;
        logic [31:0] crc;
        logic pend;
        logic ready;
        logic bid_err;
        logic [3:0] tries;
        logic [9:0] col_cnt;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [15:0] rdata;
        logic irq;
        tx_state_e st;
    } ctl_s;
endpackage

// [test/host_model.sv]
// Purpose: host side model driving the register port of transmit control
// Assumes: one strobe cycle per access, read data one cycle after strobe
// Notes: accesses start 1 ns after a rising edge; data released inverted
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.svh"
module host_model (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output var logic [11:0] addr_o,
    output var logic [15:0] wdata_o,
    output var logic wr_o,
    output var logic rd_o
);
    initial begin
        addr_o = 12'h000;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        d = rdata_i;
    endtask

    // bid: command, length, then status poll, every frame
    task automatic bid(input logic [15:0] cmd, input logic [15:0] len,
                       output logic [15:0] st);
        wr(`A_TX_CMD, cmd);
        wr(`A_TX_LEN, len);
        st = 16'h0000;
        for (int i = 0; i < 50 && st[8] !== 1'b1 && st[7] !== 1'b1; i++) begin
            rd(`A_BUS_ST, st);
        end
    endtask
endmodule
`default_nettype wire

// [test/mac_transmit_control_test.sv]
// Purpose: self-checking bench for transmit control
// Assumes: wire side stalls one cycle in eight, one collision scenario
// Notes: expected wire bytes built here from the framing rules
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.svh"
module mac_transmit_control_test;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic link = 1'b1;
    logic coll = 1'b0;
    logic tx_ready = 1'b1;
    logic [11:0] h_addr;
    logic [15:0] h_wdata;
    logic [15:0] h_rdata;
    logic [15:0] q;
    logic h_wr;
    logic h_rd;
    logic [7:0] tx_data;
    logic tx_valid;
    logic port_aui;
    logic mod_backoff;
    logic defer_dis;
    logic tx_irq;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int irq_cnt = 0;
    int irq0;
    int held;
    logic [7:0] got[$];
    logic [7:0] exp_q[$];
    logic [11:0] cfg_addr[4] = '{`A_TX_CFG, `A_BUF_CFG, `A_LINE_CTL, 12'h200};
    int lens[4] = '{40, 400, 1100, 40};
    int holds[4] = '{2, 190, 510, 19};
    int bad_lens[2] = '{2, 1515};

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // wire side back-pressure, bytes must stand until taken
    always @(posedge sys_clk) begin
        #1;
        tx_ready = (cycles % 8) != 5;
    end

    mac_transmit_control mac_transmit_control_inst (
        .SYS_CLK_I(sys_clk), .RESET_I(reset), .HOST_ADDR_I(h_addr),
        .HOST_WDATA_I(h_wdata), .HOST_WR_I(h_wr), .HOST_RD_I(h_rd),
        .HOST_RDATA_O(h_rdata), .LINK_I(link), .CARRIER_I(1'b0),
        .COLL_I(coll), .HEARTBEAT_ERR_I(1'b0), .OVERLONG_I(1'b0),
        .TX_READY_I(tx_ready), .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid),
        .PORT_AUI_O(port_aui), .MOD_BACKOFF_O(mod_backoff),
        .DEFER_2PART_DIS_O(defer_dis), .TX_IRQ_O(tx_irq)
    );

    host_model host_model_inst (
        .clk_i(sys_clk), .rdata_i(h_rdata), .addr_o(h_addr),
        .wdata_o(h_wdata), .wr_o(h_wr), .rd_o(h_rd)
    );

    always @(posedge sys_clk) begin
        cycles++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_data);
        end
        if (tx_irq === 1'b1) begin
            irq_cnt++;
        end
        if (cycles == 60000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 7 + 1);
    endfunction

    task automatic fill(input int from, input int to);
        for (int k = from; k < to; k++) begin
            host_model_inst.wr(`A_TX_DATA, {pat(2 * k + 1), pat(2 * k)});
        end
    endtask

    // preamble, delimiter, data, pad, crc lsb first
    task automatic build(input int len, input logic pad, input logic crc);
        logic [31:0] c;
        logic [7:0] b;
        int n;
        c = 32'hffffffff;
        n = (pad && len < 60) ? 60 : len;
        exp_q.delete();
        repeat (7) exp_q.push_back(8'h55);
        exp_q.push_back(8'hd5);
        for (int i = 0; i < n; i++) begin
            b = (i < len) ? pat(i) : 8'h00;
            exp_q.push_back(b);
            c = c ^ {24'h000000, b};
            repeat (8) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        if (crc) begin
            for (int i = 0; i < 4; i++) exp_q.push_back(~c[8 * i +: 8]);
        end
    endtask

    task automatic idle_check(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
        check(16'(got.size()), 16'h0000);
    endtask

    task automatic start(input logic [15:0] cmd, input int len,
                         input int hold);
        got.delete();
        host_model_inst.bid(cmd, 16'(len), q);
        check({7'h00, q[8], 8'h00}, 16'h0100);
        fill(0, hold);
        held = hold;
        idle_check(20);
    endtask

    task automatic complete(input int len, input logic pad, input logic crc);
        int quiet;
        quiet = 0;
        fill(held, (len + 1) / 2);
        for (int i = 0; i < 4000 && quiet < 4; i++) begin
            @(posedge sys_clk);
            #1;
            if (got.size() > 0 && tx_valid === 1'b0) quiet++;
        end
        build(len, pad, crc);
        check(16'(got.size()), 16'(exp_q.size()));
        for (int i = 0; i < got.size() && i < exp_q.size(); i++) begin
            check({8'h00, got[i]}, {8'h00, exp_q[i]});
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        foreach (cfg_addr[i]) begin
            host_model_inst.rd(cfg_addr[i], q);
            check(q, `RST_CFG);
        end
        // port bits changed with transmit off
        host_model_inst.wr(`A_LINE_CTL, 16'h2900);
        host_model_inst.rd(`A_LINE_CTL, q);
        check(q, 16'h2900);
        check({13'h0, port_aui, mod_backoff, defer_dis}, 16'h0007);
        host_model_inst.wr(`A_LINE_CTL, 16'h0000);
        host_model_inst.rd(`A_LINE_CTL, q);
        check({13'h0, port_aui, mod_backoff, defer_dis}, 16'h0000);
        host_model_inst.wr(`A_LINE_CTL, 16'h0080);
        host_model_inst.wr(`A_TX_CFG, 16'h0100);
        for (int t = 0; t < 4; t++) begin
            irq0 = irq_cnt;
            start({8'h00, 2'(t), 6'h00}, lens[t], holds[t]);
            complete(lens[t], 1'b1, 1'b1);
            check(16'(irq_cnt - irq0), 16'h0001);
        end
        foreach (bad_lens[i]) begin
            host_model_inst.bid(16'h0000, 16'(bad_lens[i]), q);
            check({8'h00, q[8], q[7], 6'h00}, 16'h0040);
        end
        host_model_inst.wr(`A_TX_CFG, 16'h0000);
        host_model_inst.wr(`A_BUF_CFG, 16'h0100);
        irq0 = irq_cnt;
        start(16'h2000, 20, 2);
        complete(20, 1'b0, 1'b1);
        check(16'(irq_cnt - irq0), 16'h0001);
        host_model_inst.wr(`A_BUF_CFG, 16'h0000);
        start(16'h3000, 20, 2);
        complete(20, 1'b0, 1'b0);
        // transmit disabled holds a fully buffered frame
        host_model_inst.wr(`A_LINE_CTL, 16'h0000);
        start(16'h0000, 20, 10);
        host_model_inst.wr(`A_LINE_CTL, 16'h0080);
        complete(20, 1'b1, 1'b1);
        // no link pulses on twisted pair
        link = 1'b0;
        start(16'h0000, 20, 10);
        host_model_inst.wr(`A_TEST_CTL, 16'h0080);
        complete(20, 1'b1, 1'b1);
        link = 1'b1;
        // collision mid-frame with single-attempt command drops the frame
        host_model_inst.wr(`A_TX_CFG, 16'h0800);
        irq0 = irq_cnt;
        host_model_inst.bid(16'h0200, 16'd20, q);
        fill(0, 10);
        repeat (4) @(posedge sys_clk);
        #1;
        coll = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        coll = 1'b0;
        repeat (40) @(posedge sys_clk);
        #1;
        check(16'(irq_cnt - irq0), 16'h0001);
        check({15'h0, tx_valid}, 16'h0000);
        host_model_inst.wr(`A_TX_CFG, 16'h0000);
        // buffer runs dry after the start threshold
        host_model_inst.wr(`A_BUF_CFG, 16'h0200);
        irq0 = irq_cnt;
        host_model_inst.bid(16'h0000, 16'd40, q);
        fill(0, 3);
        repeat (60) @(posedge sys_clk);
        #1;
        check(16'(irq_cnt - irq0), 16'h0001);
        check({15'h0, tx_valid}, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
